// >>> hdl/synth_cfg_regs.svh
`ifndef SYNTH_CFG_REGS_SVH
`define SYNTH_CFG_REGS_SVH

// ==========================================================
// Word layout
`define CFG_ADDR_W       4
`define CFG_DATA_W       18
`define CFG_WORD_W       22
`define CFG_ADDR_LSB     18

// ==========================================================
// Register addresses
`define CFG_ADDR_MAIN    4'h0
`define CFG_ADDR_GAIN    4'h1
`define CFG_ADDR_PWR     4'h2
`define CFG_ADDR_N_RF1   4'h3
`define CFG_ADDR_N_RF2   4'h4
`define CFG_ADDR_N_IF    4'h5
`define CFG_ADDR_R_RF1   4'h6
`define CFG_ADDR_R_RF2   4'h7
`define CFG_ADDR_R_IF    4'h8

// ==========================================================
// Field positions
`define CFG_PWR_RF_BIT   1
`define CFG_PWR_IF_BIT   0
`define CFG_AUTOKP_BIT   2
`define CFG_IFDIV_LSB    10

// ==========================================================
// Reset values
`define CFG_REG_RESET    18'h00000
`define CFG_WORD_RESET   22'h000000
`define CFG_SYNC_RESET   2'h1

`endif

// >>> hdl/synth_cfg_pkg.sv
package synth_cfg_pkg;

   // ==========================================================
   // Loop identifiers
   typedef enum logic [1:0] {
      LOOP_RF1  = 2'h0,
      LOOP_RF2  = 2'h1,
      LOOP_IF   = 2'h2,
      LOOP_NONE = 2'h3
   } loop_e;

   // ==========================================================
   // Commit sequencer, one bit flips per step except APPLY back to IDLE
   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_LATCH = 2'h1,
      ST_APPLY = 2'h3
   } commit_state_e;

   // ==========================================================
   // Control to the analog side
   typedef struct packed {
      logic       rf2_selected;
      logic       if_loop_power_on;
      logic       rf_loop_power_on;
      logic       auto_gain;
      logic [1:0] if_div_code;
      logic [3:0] if_div_ratio;
   } synth_ctrl_s;

   typedef struct packed {
      logic tune_rf1;
      logic tune_rf2;
      logic tune_if;
   } tune_req_s;

endpackage

// >>> hdl/serial_shifter.sv
`timescale 1ns/1ns
`include "synth_cfg_regs.svh"

module serial_shifter #(
   parameter int WORD_W = `CFG_WORD_W
) (
   // Link clock and reset
   input  wire logic              sclk,
   input  wire logic              rst_b,
   // Serial pins
   input  wire logic              serial_enable_n,
   input  wire logic              serial_data_in,
   // Shifted word
   output logic [WORD_W-1:0]      word
);

   generate
      if (WORD_W < 2) begin : g_bad_word
         $error("Shift register needs at least two bits");
      end
   endgenerate

   // ==========================================================
   // Shift register, MSB first, oldest bits fall off the top
   logic [WORD_W-1:0] shift_q;
   logic [WORD_W-1:0] shift_d;

   always_comb begin
      shift_d = shift_q;
      if (!serial_enable_n) begin
         shift_d = {shift_q[WORD_W-2:0], serial_data_in};
      end
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         shift_q <= '0;
      end else begin
         shift_q <= shift_d;
      end
   end

   assign word = shift_q;

endmodule

// >>> hdl/synth_three_wire_config_port.sv
`timescale 1ns/1ns
`include "synth_cfg_regs.svh"

module synth_three_wire_config_port #(
   parameter int ADDR_W = `CFG_ADDR_W,
   parameter int DATA_W = `CFG_DATA_W
) (
   // Core clock and reset
   input  wire logic                       core_clk,
   input  wire logic                       rst_b,
   // Serial link
   input  wire logic                       sclk,
   input  wire logic                       serial_enable_n,
   input  wire logic                       serial_data_in,
   // Hardware power pin
   input  wire logic                       powerdown_pin_n,
   // Register readback to the analog side
   input  wire logic [ADDR_W-1:0]          rd_addr,
   output logic [DATA_W-1:0]               rd_data,
   // Control and tuning
   output synth_cfg_pkg::synth_ctrl_s      ctrl,
   output synth_cfg_pkg::tune_req_s        tune,
   output logic                            commit_pulse
);

   localparam int WORD_W = ADDR_W + DATA_W;
   localparam int NREGS  = 1 << ADDR_W;

   // ==========================================================
   // Elaboration checks
   generate
      if (WORD_W != `CFG_WORD_W || ADDR_W != `CFG_ADDR_W) begin : g_bad_width
         $error("Word must be 4 address bits plus 18 data bits");
      end
   endgenerate

   // ==========================================================
   // Decoding of divider addresses to loops
   function automatic synth_cfg_pkg::loop_e loop_of(input logic [ADDR_W-1:0] a);
      case (a)
         `CFG_ADDR_N_RF1, `CFG_ADDR_R_RF1: loop_of = synth_cfg_pkg::LOOP_RF1;
         `CFG_ADDR_N_RF2, `CFG_ADDR_R_RF2: loop_of = synth_cfg_pkg::LOOP_RF2;
         `CFG_ADDR_N_IF,  `CFG_ADDR_R_IF:  loop_of = synth_cfg_pkg::LOOP_IF;
         default:                          loop_of = synth_cfg_pkg::LOOP_NONE;
      endcase
   endfunction

   // ==========================================================
   // Link-side shift register
   logic [WORD_W-1:0] shift_word;

   serial_shifter #(
      .WORD_W (WORD_W)
   ) u_shifter (
      .sclk            (sclk),
      .rst_b           (rst_b),
      .serial_enable_n (serial_enable_n),
      .serial_data_in  (serial_data_in),
      .word            (shift_word)
   );

   // ==========================================================
   // Pin synchronisers: bit 0 enable, bit 1 power pin
   logic [1:0] pin_raw;
   logic [1:0] pin_sync;

   assign pin_raw = {powerdown_pin_n, serial_enable_n};

   // Both stages reset to the pin's idle level, so no false edge follows reset
   localparam logic [1:0] SYNC_RST = `CFG_SYNC_RESET;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         logic [1:0] s_q;
         logic [1:0] s_d;
         always_comb begin
            s_d = {s_q[0], pin_raw[gi]};
         end
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               s_q <= {2{SYNC_RST[gi]}};
            end else begin
               s_q <= s_d;
            end
         end
         assign pin_sync[gi] = s_q[1];
      end
   endgenerate

   // ==========================================================
   // Commit and control state
   synth_cfg_pkg::commit_state_e state_q;
   synth_cfg_pkg::commit_state_e state_d;
   logic [WORD_W-1:0]            word_q;
   logic [WORD_W-1:0]            word_d;
   logic [DATA_W-1:0]            regs_q [NREGS];
   logic [DATA_W-1:0]            regs_d [NREGS];
   logic                         en_prev_q;
   logic                         rf2_sel_q;
   logic                         rf2_sel_d;
   logic                         if_on_q;
   logic                         if_on_d;
   logic                         rf_on_q;
   logic                         rf_on_d;
   logic [DATA_W-1:0]            rd_data_q;
   logic [DATA_W-1:0]            rd_data_d;
   synth_cfg_pkg::synth_ctrl_s   ctrl_q;
   synth_cfg_pkg::synth_ctrl_s   ctrl_d;
   synth_cfg_pkg::tune_req_s     tune_q;
   synth_cfg_pkg::tune_req_s     tune_d;
   synth_cfg_pkg::tune_req_s     tune_s_q;
   logic                         commit_q;
   logic                         commit_d;

   logic [ADDR_W-1:0]            wr_addr;
   logic [DATA_W-1:0]            wr_data;
   synth_cfg_pkg::loop_e         wr_loop;
   logic                         wr_en;
   logic                         freq_change;
   logic                         rf_up;
   logic                         if_up;

   assign wr_addr = word_q[WORD_W-1:DATA_W];
   assign wr_data = word_q[DATA_W-1:0];
   assign wr_loop = loop_of(wr_addr);

   always_comb begin
      state_d   = state_q;
      word_d    = word_q;
      regs_d    = regs_q;
      rf2_sel_d = rf2_sel_q;
      wr_en     = 1'b0;
      commit_d  = 1'b0;

      case (state_q)
         synth_cfg_pkg::ST_IDLE: begin
            if (pin_sync[0] && !en_prev_q) begin
               state_d = synth_cfg_pkg::ST_LATCH;
            end
         end
         synth_cfg_pkg::ST_LATCH: begin
            // Shifter is frozen while enable is high, so the word is stable
            word_d  = shift_word;
            state_d = synth_cfg_pkg::ST_APPLY;
         end
         synth_cfg_pkg::ST_APPLY: begin
            wr_en   = 1'b1;
            state_d = synth_cfg_pkg::ST_IDLE;
         end
         default: begin
            state_d = synth_cfg_pkg::ST_IDLE;
         end
      endcase

      // A new frequency is a changed value or a switch of RF loop
      freq_change = wr_en && (wr_loop != synth_cfg_pkg::LOOP_NONE) &&
                    ((wr_data != regs_q[wr_addr]) ||
                     (wr_loop == synth_cfg_pkg::LOOP_RF1 && rf2_sel_q) ||
                     (wr_loop == synth_cfg_pkg::LOOP_RF2 && !rf2_sel_q));

      if (wr_en) begin
         regs_d[wr_addr] = wr_data;
         commit_d        = 1'b1;
         if (wr_loop == synth_cfg_pkg::LOOP_RF1) begin
            rf2_sel_d = 1'b0;
         end else if (wr_loop == synth_cfg_pkg::LOOP_RF2) begin
            rf2_sel_d = 1'b1;
         end
      end

      // Loop runs when the pin and its register bit both ask for it
      if_on_d = pin_sync[1] && regs_q[`CFG_ADDR_PWR][`CFG_PWR_IF_BIT];
      rf_on_d = pin_sync[1] && regs_q[`CFG_ADDR_PWR][`CFG_PWR_RF_BIT];
      if_up   = if_on_d && !if_on_q;
      rf_up   = rf_on_d && !rf_on_q;

      tune_d.tune_if  = if_up ||
                        (if_on_d && freq_change && wr_loop == synth_cfg_pkg::LOOP_IF);
      tune_d.tune_rf1 = (rf_up && !rf2_sel_q) ||
                        (rf_on_d && freq_change && wr_loop == synth_cfg_pkg::LOOP_RF1);
      tune_d.tune_rf2 = (rf_up && rf2_sel_q) ||
                        (rf_on_d && freq_change && wr_loop == synth_cfg_pkg::LOOP_RF2);

      ctrl_d.rf2_selected     = rf2_sel_q;
      ctrl_d.if_loop_power_on = if_on_q;
      ctrl_d.rf_loop_power_on = rf_on_q;
      ctrl_d.auto_gain        = regs_q[`CFG_ADDR_MAIN][`CFG_AUTOKP_BIT];
      ctrl_d.if_div_code      = regs_q[`CFG_ADDR_MAIN][`CFG_IFDIV_LSB +: 2];
      ctrl_d.if_div_ratio     = 4'h1 << ctrl_d.if_div_code;

      rd_data_d = regs_q[rd_addr];
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q   <= synth_cfg_pkg::ST_IDLE;
         word_q    <= `CFG_WORD_RESET;
         for (int i = 0; i < NREGS; i++) begin
            regs_q[i] <= `CFG_REG_RESET;
         end
         en_prev_q <= 1'b1;
         rf2_sel_q <= 1'b0;
         if_on_q   <= 1'b0;
         rf_on_q   <= 1'b0;
         rd_data_q <= `CFG_REG_RESET;
         ctrl_q    <= '{if_div_ratio: 4'h1, default: '0};
         tune_s_q  <= '0;
         tune_q    <= '0;
         commit_q  <= 1'b0;
      end else begin
         state_q   <= state_d;
         word_q    <= word_d;
         regs_q    <= regs_d;
         en_prev_q <= pin_sync[0];
         rf2_sel_q <= rf2_sel_d;
         if_on_q   <= if_on_d;
         rf_on_q   <= rf_on_d;
         rd_data_q <= rd_data_d;
         ctrl_q    <= ctrl_d;
         // Tune waits one stage so it meets the control word naming its loop
         tune_s_q  <= tune_d;
         tune_q    <= tune_s_q;
         commit_q  <= commit_d;
      end
   end

   // ==========================================================
   // Outputs
   assign rd_data      = rd_data_q;
   assign ctrl         = ctrl_q;
   assign tune         = tune_q;
   assign commit_pulse = commit_q;

endmodule

// >>> verification/synth_cfg_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker
module synth_cfg_checker #(
   parameter int ADDR_W = 4,
   parameter int DATA_W = 18
) (
   // Clocks and inputs
   input wire logic                        core_clk,
   input wire logic                        rst_b,
   input wire logic                        sclk,
   input wire logic                        serial_enable_n,
   input wire logic                        serial_data_in,
   input wire logic                        powerdown_pin_n,
   input wire logic [ADDR_W-1:0]           rd_addr,
   // Outputs
   input wire logic [DATA_W-1:0]           rd_data,
   input wire synth_cfg_pkg::synth_ctrl_s  ctrl,
   input wire synth_cfg_pkg::tune_req_s    tune,
   input wire logic                        commit_pulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   AST_COMMIT_AFTER_RISE: assert property ($rose(serial_enable_n) |-> ##[4:7] commit_pulse)
      else $error("no commit after enable rise");
   AST_COMMIT_CAUSE: assert property (commit_pulse |-> $past(serial_enable_n, 3))
      else $error("commit without enable high");
   AST_DIV_RATIO: assert property (ctrl.if_div_ratio == (4'h1 << ctrl.if_div_code))
      else $error("divide ratio does not match code");
   AST_IF_TUNE_POWERED: assert property (tune.tune_if |-> ctrl.if_loop_power_on)
      else $error("if tune while powered off");
   AST_IF_TUNE_ON_POWERUP: assert property ($rose(ctrl.if_loop_power_on) |-> ##[0:2] tune.tune_if)
      else $error("no if tune after power up");
   AST_RF2_TUNE_ACTIVE: assert property (tune.tune_rf2 |-> ctrl.rf2_selected && ctrl.rf_loop_power_on)
      else $error("tune of inactive second loop");
   AST_RF1_TUNE_ACTIVE: assert property (tune.tune_rf1 |-> !ctrl.rf2_selected && ctrl.rf_loop_power_on)
      else $error("tune of inactive first loop");
   AST_DIV_CODE_ON_COMMIT: assert property ($changed(ctrl.if_div_code) |-> $past(commit_pulse) || $past(commit_pulse, 2))
      else $error("divide code moved without commit");
   AST_SELECT_ON_COMMIT: assert property ($changed(ctrl.rf2_selected) |-> $past(commit_pulse) || $past(commit_pulse, 2))
      else $error("loop select moved without commit");
   AST_PIN_POWERS_DOWN: assert property (!powerdown_pin_n [*4] |=> !ctrl.if_loop_power_on && !ctrl.rf_loop_power_on)
      else $error("power stays on with pin low");
endmodule

bind synth_three_wire_config_port synth_cfg_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk (
   .core_clk(core_clk), .rst_b(rst_b), .sclk(sclk), .serial_enable_n(serial_enable_n),
   .serial_data_in(serial_data_in), .powerdown_pin_n(powerdown_pin_n), .rd_addr(rd_addr),
   .rd_data(rd_data), .ctrl(ctrl), .tune(tune), .commit_pulse(commit_pulse));

// >>> verification/host_serial_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host on the three-wire link
module host_serial_model (
   // Serial pins
   output logic sclk,
   output logic serial_enable_n,
   output logic serial_data_in
);
   initial begin
      sclk = 1'b0;
      serial_enable_n = 1'b1;
      serial_data_in = 1'b0;
   end
   task automatic shift(input logic b);
      serial_data_in <= b;
      #15 sclk <= 1'b1;
      #15 sclk <= 1'b0;
   endtask
   task automatic frame(input logic [21:0] word, input logic [9:0] lead, input bit with_lead);
      serial_enable_n <= 1'b0;
      #12;
      if (with_lead) for (int i = 9; i >= 0; i--) shift(lead[i]);
      for (int i = 21; i >= 0; i--) shift(word[i]);
      #15 serial_enable_n <= 1'b1;
      serial_data_in <= ~serial_data_in;
      #90;
   endtask
   task automatic idle_clocks(input int n);
      for (int i = 0; i < n; i++) shift(i[0]);
   endtask
endmodule

// >>> verification/test_synth_three_wire_config_port.sv
`timescale 1ns/1ns
// ==========================================================
// Bench
module test_synth_three_wire_config_port;
   logic                       core_clk = 1'b0;
   logic                       rst_b = 1'b0;
   logic                       powerdown_pin_n = 1'b0;
   logic [3:0]                 rd_addr = 4'h0;
   logic                       sclk;
   logic                       serial_enable_n;
   logic                       serial_data_in;
   logic                       commit_pulse;
   logic [17:0]                rd_data;
   synth_cfg_pkg::synth_ctrl_s ctrl;
   synth_cfg_pkg::tune_req_s   tune;
   int                         mismatches = 0;
   int                         samples_checked = 0;
   int                         commits = 0;
   int                         if_tunes = 0;
   int                         rf_tunes = 0;
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (commit_pulse === 1'b1) commits <= commits + 1;
      if (tune.tune_if === 1'b1) if_tunes <= if_tunes + 1;
      if ((tune.tune_rf1 | tune.tune_rf2) === 1'b1) rf_tunes <= rf_tunes + 1;
   end
   synth_three_wire_config_port dut (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
      .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in), .powerdown_pin_n(powerdown_pin_n),
      .rd_addr(rd_addr), .rd_data(rd_data), .ctrl(ctrl), .tune(tune), .commit_pulse(commit_pulse));
   host_serial_model host (.sclk(sclk), .serial_enable_n(serial_enable_n), .serial_data_in(serial_data_in));
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [17:0] exp);
      @(posedge core_clk) rd_addr <= a;
      repeat (2) @(posedge core_clk);
      #1 check(rd_data, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [17:0] d);
      int c0;
      c0 = commits;
      host.frame({a, d}, 10'h0, 1'b0);
      check(18'(commits - c0), 18'h1);
   endtask
   task automatic test_done;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_write_read;
      check(18'(ctrl), 18'h00001);
      for (int a = 0; a <= 8; a++) wr(4'(a), 18'h2C3A0 + 18'(a << 4));
      for (int a = 0; a <= 8; a++) rd(4'(a), 18'h2C3A0 + 18'(a << 4));
   endtask
   task automatic test_long_and_idle;
      int c0;
      host.frame({4'h5, 18'h1234C}, 10'h3FF, 1'b1);
      rd(4'h5, 18'h1234C);
      c0 = commits;
      host.idle_clocks(30);
      repeat (10) @(posedge core_clk);
      check(18'(commits - c0), 18'h0);
      rd(4'h5, 18'h1234C);
   endtask
   task automatic test_if_div;
      for (int c = 0; c < 4; c++) begin
         wr(4'h0, (18'(c) << 10) | (18'(c % 2) << 2));
         check(18'(ctrl.auto_gain), 18'(c % 2));
         check(18'(ctrl.if_div_code), 18'(c));
         check(18'(ctrl.if_div_ratio), 18'h1 << c);
      end
   endtask
   task automatic test_rf_select;
      logic [3:0] addrs [4] = '{4'h4, 4'h6, 4'h7, 4'h3};
      for (int i = 0; i < 4; i++) begin
         wr(addrs[i], 18'h00100 + 18'(i));
         check(18'(ctrl.rf2_selected), 18'(i % 2 == 0));
      end
   endtask
   task automatic test_power_tune;
      int t0;
      int r0;
      @(posedge core_clk) powerdown_pin_n <= 1'b1;
      repeat (5) @(posedge core_clk);
      t0 = if_tunes;
      r0 = rf_tunes;
      wr(4'h2, 18'h00003);
      check(18'({ctrl.if_loop_power_on, ctrl.rf_loop_power_on}), 18'h3);
      check(18'(if_tunes - t0), 18'h1);
      check(18'(rf_tunes - r0), 18'h1);
      wr(4'h5, 18'h00777);
      check(18'(if_tunes - t0), 18'h2);
      wr(4'h4, 18'h00555);
      check(18'(ctrl.rf2_selected), 18'h1);
      check(18'(rf_tunes - r0), 18'h2);
      @(posedge core_clk) powerdown_pin_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      check(18'({ctrl.if_loop_power_on, ctrl.rf_loop_power_on}), 18'h0);
      @(posedge core_clk) powerdown_pin_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      check(18'(if_tunes - t0), 18'h3);
      wr(4'h2, 18'h00000);
      check(18'({ctrl.if_loop_power_on, ctrl.rf_loop_power_on}), 18'h0);
   endtask
   initial begin
      #200000;
      mismatches++;
      test_done;
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      test_write_read;
      test_long_and_idle;
      test_if_div;
      test_rf_select;
      test_power_tune;
      test_done;
   end
endmodule
